// *** flash_rewrite_pkg.sv ***
// constants, carrier types and states of the flash rewrite status block
// How it works
// - erase may be suspended in running-cpu mode
// - suspended erase allows array reads and programming
// - finish or suspend returns to read-array mode
// - held-cpu mode stalls cpu during program/erase
// - running mode suspends on request or interrupt
// - held mode suspends only on enabled interrupt
// - status at 1B2h, resets to 80h
// - ready request flag set by hardware only
// - access error flag hardware set, read-then-zero clear
// - bit 4 shows program error
// - bit 5 shows erase or blank-check error
// - command error sets both error bits
// - bit 6 shows erase-suspend state
// - bit 3 always reads zero
// - request flags raise only when their enables are set
// - busy to ready raises ready request
// - busy block access or errors raise access flag
// - lock monitor updates on program, erase or lock-read completion
// - ready bit low whenever flash is busy
package flash_rewrite_pkg;

  localparam int ADDR_W   = 10;
  localparam int DATA_W   = 8;
  localparam int BLOCK_W  = 4;
  localparam int NUM_BLK  = 16;

  localparam int CLK_PERIOD_NS = 5;
  localparam int POWER_TIME_NS = 1000;
  localparam int POWER_CYCLES  = (POWER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 10'h1B2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL0   = 10'h1B4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2   = 10'h1B6;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 10'h1B8;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK   = 10'h1BA;
  localparam logic [ADDR_W-1:0] ADDR_DATA    = 10'h1BC;

  // flash_status fields
  localparam int FS_RDY_REQ   = 0;
  localparam int FS_ACC_REQ   = 1;
  localparam int FS_LOCK      = 2;
  localparam int FS_PROG_ERR  = 4;
  localparam int FS_ERASE_ERR = 5;
  localparam int FS_SUSPEND   = 6;
  localparam int FS_READY     = 7;

  // flash_control0 fields
  localparam int C0_REWRITE = 1;
  localparam int C0_HELD    = 2;
  localparam int C0_STOP    = 3;
  localparam int C0_ABORT   = 4;
  localparam int C0_ERR_IE  = 5;
  localparam int C0_ACC_IE  = 6;
  localparam int C0_RDY_IE  = 7;

  // flash_control2 fields
  localparam int C2_SUSP_EN  = 0;
  localparam int C2_SUSP_REQ = 1;
  localparam int C2_INT_SUSP = 2;

  localparam logic [DATA_W-1:0] CMD_PROGRAM   = 8'h01;
  localparam logic [DATA_W-1:0] CMD_ERASE     = 8'h02;
  localparam logic [DATA_W-1:0] CMD_BLANK     = 8'h03;
  localparam logic [DATA_W-1:0] CMD_LOCK_PROG = 8'h04;
  localparam logic [DATA_W-1:0] CMD_LOCK_READ = 8'h05;
  localparam logic [DATA_W-1:0] CMD_CLEAR     = 8'h06;
  localparam logic [DATA_W-1:0] CMD_RESUME    = 8'h07;

  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h80;

  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_PROGRAM   = 3'h1,
    OP_ERASE     = 3'h2,
    OP_BLANK     = 3'h3,
    OP_LOCK_PROG = 3'h4,
    OP_LOCK_READ = 3'h5
  } op_t;

  typedef enum logic [6:0] {
    S_IDLE      = 7'h01,
    S_OP        = 7'h02,
    S_SUSP_WAIT = 7'h04,
    S_SUSPENDED = 7'h08,
    S_ABORT     = 7'h10,
    S_POWER     = 7'h20,
    S_STOPPED   = 7'h40
  } fsm_t;

  typedef struct packed {
    logic               start;
    op_t                op;
    logic [BLOCK_W-1:0] block;
    logic [DATA_W-1:0]  data;
    logic               abort;
    logic               suspend;
    logic               resume;
  } array_req_t;

  typedef struct packed {
    logic done;
    logic fail;
    logic locked;
    logic suspended;
  } array_rsp_t;

  typedef struct packed {
    logic               valid;
    logic [BLOCK_W-1:0] block;
  } cpu_access_t;

endpackage

// *** flash_power_timer.sv ***
// one-shot timer for flash stop and activation delays
`timescale 1ns/100ps
`default_nettype none
module flash_power_timer #(
  parameter int unsigned CYCLES = 200
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_load,
  output logic      o_done
);
  localparam int CNT_W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             run;
    logic             done;
  } tmr_t;

  tmr_t st;
  tmr_t nx;

  always_comb begin
    nx      = st;
    nx.done = 1'b0;
    if (i_load) begin
      nx.cnt = CNT_W'(CYCLES);
      nx.run = 1'b1;
    end else if (st.run) begin
      if (st.cnt <= CNT_W'(1)) begin
        nx.run  = 1'b0;
        nx.done = 1'b1;
      end else begin
        nx.cnt = st.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign o_done = st.done;
endmodule
`default_nettype wire

// *** flash_self_rewrite_status.sv ***
// flash rewrite sequencer: status register, modes, suspend and error flags
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module flash_self_rewrite_status
  import flash_rewrite_pkg::*;
#(
  parameter int NUM_BLOCKS   = NUM_BLK,
  parameter int POWER_CYCLE_N = POWER_CYCLES
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  output logic      [DATA_W-1:0] o_rd_data,
  input  wire logic              i_maskable_irq,
  input  wire cpu_access_t       i_access,
  input  wire array_rsp_t        i_array,
  output array_req_t             o_array,
  output logic                   o_cpu_hold,
  output logic                   o_read_array_mode,
  output logic                   o_access_blocked
);

  typedef struct packed {
    fsm_t               fsm;
    op_t                op;
    logic [BLOCK_W-1:0] blk;
    logic [BLOCK_W-1:0] ers_blk;
    logic               susp_prog;
    logic               rewrite_en;
    logic               held_mode;
    logic               stop_bit;
    logic               err_ie;
    logic               acc_ie;
    logic               rdy_ie;
    logic               susp_en;
    logic               susp_req;
    logic               int_susp_en;
    logic [BLOCK_W-1:0] sel_blk;
    logic [DATA_W-1:0]  wdat;
    logic               rdy_req;
    logic               acc_req;
    logic               rdy_armed;
    logic               acc_armed;
    logic               prog_err;
    logic               erase_err;
    logic               lock_mon;
    logic               was_ready;
    logic [DATA_W-1:0]  rd_data;
    array_req_t         arr;
    logic               cpu_hold;
    logic               read_mode;
    logic               blocked;
    logic               timer_load;
  } core_t;

  core_t st;
  core_t nx;
  logic  timer_done;

  ////////////////////////////////////////////////////////////////////////////
  // stop and activation delay

  flash_power_timer #(
    .CYCLES (POWER_CYCLE_N)
  ) u_power_timer (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_load     (st.timer_load),
    .o_done     (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic              ready_now;
    logic              busy_op;
    logic              susp_hit;
    logic              cmd_wr;
    logic              req_clear;
    logic              req_resume;
    logic              bad_code;
    logic              blk_ok;
    logic              cmd_err;
    logic              set_pe;
    logic              set_ee;
    logic              set_acc;
    logic              clr_rdy;
    logic              clr_acc;
    logic              hit;
    op_t               req_op;
    logic [DATA_W-1:0] status;

    ready_now  = st.fsm inside {S_IDLE, S_SUSPENDED, S_STOPPED};
    busy_op    = st.fsm inside {S_OP, S_SUSP_WAIT};
    cmd_wr     = i_wr_en && (i_addr == ADDR_COMMAND) && st.rewrite_en;
    req_op     = OP_NONE;
    req_clear  = 1'b0;
    req_resume = 1'b0;
    bad_code   = 1'b0;
    blk_ok     = int'(st.sel_blk) < NUM_BLOCKS;
    cmd_err    = 1'b0;
    set_pe     = 1'b0;
    set_ee     = 1'b0;
    set_acc    = 1'b0;
    clr_rdy    = 1'b0;
    clr_acc    = 1'b0;
    hit        = 1'b0;
    status     = '0;

    nx                = st;
    nx.arr.start      = 1'b0;
    nx.arr.abort      = 1'b0;
    nx.arr.resume     = 1'b0;
    nx.timer_load     = 1'b0;
    nx.rd_data        = '0;

    // the running-cpu mode also honours the software request bit
    susp_hit = st.susp_en && st.int_susp_en && i_maskable_irq;
    if (!st.held_mode && st.susp_en && st.susp_req) begin
      susp_hit = 1'b1;
    end

    unique case (i_wr_data)
      CMD_PROGRAM:   req_op = OP_PROGRAM;
      CMD_ERASE:     req_op = OP_ERASE;
      CMD_BLANK:     req_op = OP_BLANK;
      CMD_LOCK_PROG: req_op = OP_LOCK_PROG;
      CMD_LOCK_READ: req_op = OP_LOCK_READ;
      CMD_CLEAR:     req_clear = 1'b1;
      CMD_RESUME:    req_resume = 1'b1;
      default:       bad_code = 1'b1;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // register reads

    status[FS_RDY_REQ]   = st.rdy_req;
    status[FS_ACC_REQ]   = st.acc_req;
    status[FS_LOCK]      = st.lock_mon;
    status[FS_PROG_ERR]  = st.prog_err;
    status[FS_ERASE_ERR] = st.erase_err;
    status[FS_SUSPEND]   = st.fsm == S_SUSPENDED;
    status[FS_READY]     = ready_now;

    if (i_rd_en) begin
      unique case (i_addr)
        ADDR_STATUS: begin
          nx.rd_data   = status;
          nx.rdy_armed = st.rdy_req;
          nx.acc_armed = st.acc_req;
        end
        ADDR_CTRL0: begin
          nx.rd_data[C0_REWRITE] = st.rewrite_en;
          nx.rd_data[C0_HELD]    = st.held_mode;
          nx.rd_data[C0_STOP]    = st.stop_bit;
          nx.rd_data[C0_ERR_IE]  = st.err_ie;
          nx.rd_data[C0_ACC_IE]  = st.acc_ie;
          nx.rd_data[C0_RDY_IE]  = st.rdy_ie;
        end
        ADDR_CTRL2: begin
          nx.rd_data[C2_SUSP_EN]  = st.susp_en;
          nx.rd_data[C2_SUSP_REQ] = st.susp_req;
          nx.rd_data[C2_INT_SUSP] = st.int_susp_en;
        end
        ADDR_BLOCK: nx.rd_data = {{(DATA_W-BLOCK_W){1'b0}}, st.sel_blk};
        ADDR_DATA:  nx.rd_data = st.wdat;
        default:    nx.rd_data = '0;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // register writes

    if (i_wr_en) begin
      unique case (i_addr)
        ADDR_STATUS: begin
          // a zero clears only after the flag was seen set; a one is ignored
          clr_rdy      = st.rdy_armed && !i_wr_data[FS_RDY_REQ];
          clr_acc      = st.acc_armed && !i_wr_data[FS_ACC_REQ];
          nx.rdy_armed = 1'b0;
          nx.acc_armed = 1'b0;
        end
        ADDR_CTRL0: begin
          nx.rewrite_en = i_wr_data[C0_REWRITE];
          nx.held_mode  = i_wr_data[C0_HELD];
          nx.stop_bit   = i_wr_data[C0_STOP];
          nx.err_ie     = i_wr_data[C0_ERR_IE];
          nx.acc_ie     = i_wr_data[C0_ACC_IE];
          nx.rdy_ie     = i_wr_data[C0_RDY_IE];
        end
        ADDR_CTRL2: begin
          nx.susp_en     = i_wr_data[C2_SUSP_EN];
          nx.susp_req    = i_wr_data[C2_SUSP_REQ];
          nx.int_susp_en = i_wr_data[C2_INT_SUSP];
        end
        ADDR_BLOCK: nx.sel_blk = i_wr_data[BLOCK_W-1:0];
        ADDR_DATA:  nx.wdat = i_wr_data;
        default:    nx.wdat = st.wdat;
      endcase
    end

    if (cmd_wr && req_clear) begin
      nx.prog_err  = 1'b0;
      nx.erase_err = 1'b0;
      clr_acc      = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // sequencer

    unique case (st.fsm)
      S_IDLE: begin
        if (st.rewrite_en && st.stop_bit) begin
          nx.fsm        = S_POWER;
          nx.timer_load = 1'b1;
        end else if (cmd_wr && !req_clear) begin
          if (bad_code || req_resume || !blk_ok) begin
            cmd_err = 1'b1;
          end else begin
            nx.arr.start = 1'b1;
            nx.arr.op    = req_op;
            nx.arr.block = st.sel_blk;
            nx.arr.data  = st.wdat;
            nx.op        = req_op;
            nx.blk       = st.sel_blk;
            nx.fsm       = S_OP;
          end
        end
      end
      S_OP, S_SUSP_WAIT: begin
        if (i_array.done) begin
          if (i_array.fail) begin
            set_pe = st.op inside {OP_PROGRAM, OP_LOCK_PROG};
            set_ee = st.op inside {OP_ERASE, OP_BLANK};
            set_acc = st.err_ie;
          end
          if (st.op inside {OP_PROGRAM, OP_ERASE, OP_LOCK_READ}) begin
            nx.lock_mon = !i_array.locked;
          end
          // back to read-array, or to the suspended erase after a program
          nx.fsm         = st.susp_prog ? S_SUSPENDED : S_IDLE;
          nx.arr.suspend = st.susp_prog;
          nx.susp_prog   = 1'b0;
        end else if (st.fsm == S_SUSP_WAIT && i_array.suspended) begin
          nx.fsm     = S_SUSPENDED;
          nx.ers_blk = st.blk;
        end else if (st.fsm == S_OP && st.op == OP_ERASE && susp_hit) begin
          nx.fsm         = S_SUSP_WAIT;
          nx.arr.suspend = 1'b1;
        end
        if (cmd_wr && !req_clear) begin
          cmd_err = 1'b1;
        end
      end
      S_SUSPENDED: begin
        if (cmd_wr && req_resume) begin
          // the array request shows the erase again, not the program run in between
          nx.arr.resume  = 1'b1;
          nx.arr.suspend = 1'b0;
          nx.arr.op      = OP_ERASE;
          nx.arr.block   = st.ers_blk;
          nx.susp_req    = 1'b0;
          nx.op          = OP_ERASE;
          nx.blk         = st.ers_blk;
          nx.fsm         = S_OP;
        end else if (cmd_wr && req_op == OP_PROGRAM && blk_ok) begin
          nx.arr.start = 1'b1;
          nx.arr.op    = OP_PROGRAM;
          nx.arr.block = st.sel_blk;
          nx.arr.data  = st.wdat;
          nx.op        = OP_PROGRAM;
          nx.blk       = st.sel_blk;
          nx.susp_prog = 1'b1;
          nx.fsm       = S_OP;
        end else if (cmd_wr && !req_clear) begin
          cmd_err = 1'b1;
        end
      end
      S_ABORT: begin
        if (i_array.done) begin
          nx.fsm         = S_IDLE;
          nx.susp_prog   = 1'b0;
        end
        if (cmd_wr && !req_clear) begin
          cmd_err = 1'b1;
        end
      end
      S_POWER: begin
        if (timer_done) begin
          nx.fsm = (st.rewrite_en && st.stop_bit) ? S_STOPPED : S_IDLE;
        end
        if (cmd_wr && !req_clear) begin
          cmd_err = 1'b1;
        end
      end
      S_STOPPED: begin
        if (!(st.rewrite_en && st.stop_bit)) begin
          nx.fsm        = S_POWER;
          nx.timer_load = 1'b1;
        end
        if (cmd_wr && !req_clear) begin
          cmd_err = 1'b1;
        end
      end
      default: begin
        nx.fsm = S_IDLE;
      end
    endcase

    // forced stop wins over any transition of the sequencer this cycle
    if (i_wr_en && i_addr == ADDR_CTRL0 && i_wr_data[C0_ABORT] && st.rewrite_en
        && st.fsm inside {S_OP, S_SUSP_WAIT, S_SUSPENDED}) begin
      nx.fsm        = S_ABORT;
      nx.arr.abort  = 1'b1;
      // a suspend level left high would halt the array again and lose the abort's done
      nx.arr.suspend = 1'b0;
      nx.arr.start  = 1'b0;
      nx.arr.resume = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////
    // flags: every set below overrides a clear in the same cycle

    if (cmd_err) begin
      set_pe  = 1'b1;
      set_ee  = 1'b1;
      set_acc = st.err_ie;
    end

    // reads return undefined data and writes are dropped on the busy block
    hit = i_access.valid && busy_op && (i_access.block == st.blk);
    if (hit && st.acc_ie) begin
      set_acc = 1'b1;
    end

    if (set_pe) begin
      nx.prog_err = 1'b1;
    end
    if (set_ee) begin
      nx.erase_err = 1'b1;
    end
    if (clr_rdy) begin
      nx.rdy_req = 1'b0;
    end
    if (clr_acc) begin
      nx.acc_req = 1'b0;
    end
    if (ready_now && !st.was_ready && st.rdy_ie) begin
      nx.rdy_req = 1'b1;
    end
    if (set_acc) begin
      nx.acc_req = 1'b1;
    end
    nx.was_ready = ready_now;

    //////////////////////////////////////////////////////////////////////////
    // registered outputs

    nx.blocked   = hit;
    nx.read_mode = nx.fsm inside {S_IDLE, S_SUSPENDED};
    nx.cpu_hold  = nx.held_mode && (nx.fsm == S_OP)
                   && (nx.op inside {OP_PROGRAM, OP_ERASE});
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st           <= '0;
      st.fsm       <= S_IDLE;
      st.op        <= OP_NONE;
      st.arr.op    <= OP_NONE;
      st.was_ready <= STATUS_RESET[FS_READY];
      st.read_mode <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign o_rd_data         = st.rd_data;
  assign o_array           = st.arr;
  assign o_cpu_hold        = st.cpu_hold;
  assign o_read_array_mode = st.read_mode;
  assign o_access_blocked  = st.blocked;

endmodule
`default_nettype wire

// *** flash_status_checker_assertions.sv ***
// port assertions for the flash rewrite status block
`timescale 1ns/100ps
`default_nettype none
module flash_status_checker
  import flash_rewrite_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_reset_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic              i_rd_en,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire cpu_access_t       i_access,
  input wire array_rsp_t        i_array,
  input wire array_req_t        o_array,
  input wire logic              o_cpu_hold,
  input wire logic              o_read_array_mode,
  input wire logic              o_access_blocked
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_bit3_zero: assert property (
    $past(i_rd_en && i_addr == ADDR_STATUS) |-> !o_rd_data[3])
    else $error("status bit 3 read as one");
  a_cmd_reads_zero: assert property (
    $past(i_rd_en && i_addr == ADDR_COMMAND) |-> o_rd_data == 8'h00)
    else $error("command register read not zero");
  a_busy_on_start: assert property (
    $past(i_rd_en && i_addr == ADDR_STATUS && o_array.start) |-> !o_rd_data[7])
    else $error("ready shown while operation starts");
  a_suspend_erase: assert property (
    $rose(o_array.suspend) |-> o_array.op == OP_ERASE)
    else $error("suspend raised outside erase");
  a_resume_readable: assert property (
    o_array.resume |-> $past(o_read_array_mode))
    else $error("resume issued while not suspended");
  a_hold_start: assert property (
    $rose(o_cpu_hold) |-> o_array.start || o_array.resume)
    else $error("cpu hold without operation start");
  a_hold_op: assert property (
    o_cpu_hold |-> o_array.op inside {OP_PROGRAM, OP_ERASE})
    else $error("cpu hold for wrong operation");
  a_done_readable: assert property (
    i_array.done |-> ##[1:2] o_read_array_mode)
    else $error("no read-array mode after done");
  a_blocked_cause: assert property (
    o_access_blocked |-> $past(i_access.valid) && $past(i_access.block) == o_array.block)
    else $error("access block without busy block hit");
  c_suspend: cover property ($rose(o_array.suspend));
  c_hold: cover property (o_cpu_hold);
  c_blocked: cover property (o_access_blocked);
endmodule
bind flash_self_rewrite_status flash_status_checker i_flash_status_checker (
  .i_core_clk        (i_core_clk),
  .i_reset_n         (i_reset_n),
  .i_addr            (i_addr),
  .i_rd_en           (i_rd_en),
  .o_rd_data         (o_rd_data),
  .i_access          (i_access),
  .i_array           (i_array),
  .o_array           (o_array),
  .o_cpu_hold        (o_cpu_hold),
  .o_read_array_mode (o_read_array_mode),
  .o_access_blocked  (o_access_blocked)
);
`default_nettype wire

// *** flash_array_model.sv ***
// behavioural flash array answering the sequencer's requests
`timescale 1ns/100ps
`default_nettype none
module flash_array_model
  import flash_rewrite_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset_n,
  input  wire array_req_t i_req,
  input  wire logic       i_fail,
  input  wire logic       i_locked,
  input  wire logic [7:0] i_delay,
  output var array_rsp_t  o_rsp
);
  logic [7:0] cnt;
  logic [7:0] saved;
  logic       halted;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt    <= 8'h00;
      saved  <= 8'h00;
      halted <= 1'b0;
      o_rsp  <= '0;
    end else begin
      o_rsp.done      <= 1'b0;
      o_rsp.suspended <= 1'b0;
      // result lines carry junk outside the done cycle
      o_rsp.fail   <= (cnt == 8'h01) ? i_fail : ~i_fail;
      o_rsp.locked <= (cnt == 8'h01) ? i_locked : ~i_locked;
      if (i_req.start) begin
        cnt <= i_delay;
      end else if (i_req.resume) begin
        cnt    <= saved;
        halted <= 1'b0;
      end else if (i_req.abort) begin
        cnt    <= 8'h02;
        halted <= 1'b0;
      end else if (i_req.suspend && !halted && cnt > 8'h01) begin
        halted          <= 1'b1;
        saved           <= cnt;
        cnt             <= 8'h00;
        o_rsp.suspended <= 1'b1;
      end else if (cnt == 8'h01) begin
        cnt        <= 8'h00;
        o_rsp.done <= 1'b1;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// register-level tests of the flash rewrite status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import flash_rewrite_pkg::*;
  localparam logic [7:0] ROW_CMD [7] = '{CMD_PROGRAM, CMD_ERASE, CMD_BLANK, CMD_LOCK_PROG,
                                         CMD_LOCK_READ, CMD_PROGRAM, CMD_ERASE};
  localparam op_t        ROW_OP  [7] = '{OP_PROGRAM, OP_ERASE, OP_BLANK, OP_LOCK_PROG,
                                         OP_LOCK_READ, OP_PROGRAM, OP_ERASE};
  localparam logic [7:0] ROW_ERR [7] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h10, 8'h20};
  localparam logic [6:0] ROW_FAIL = 7'h64;
  localparam logic [6:0] ROW_LOCK = 7'h12;
  localparam logic [6:0] ROW_UPD  = 7'h73;
  logic              core_clk = 1'b0;
  logic              reset_n  = 1'b0;
  logic [ADDR_W-1:0] addr     = '0;
  logic [DATA_W-1:0] wr_data  = '0;
  logic              wr_en    = 1'b0;
  logic              rd_en    = 1'b0;
  logic              irq      = 1'b0;
  cpu_access_t       access   = '0;
  logic              fail     = 1'b0;
  logic              locked   = 1'b0;
  logic [7:0]        delay    = 8'h08;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] s;
  array_rsp_t        rsp;
  array_req_t        req;
  logic              cpu_hold;
  logic              array_mode;
  logic              blocked;
  int                n_fail   = 0;
  int                checks   = 0;
  always #2.5 core_clk = ~core_clk;
  flash_self_rewrite_status #(.POWER_CYCLE_N(4)) i_flash_self_rewrite_status (
    .i_core_clk(core_clk), .i_reset_n(reset_n), .i_addr(addr), .i_wr_data(wr_data),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_maskable_irq(irq),
    .i_access(access), .i_array(rsp), .o_array(req), .o_cpu_hold(cpu_hold),
    .o_read_array_mode(array_mode), .o_access_blocked(blocked));
  flash_array_model i_flash_array_model (
    .i_core_clk(core_clk), .i_reset_n(reset_n), .i_req(req), .i_fail(fail),
    .i_locked(locked), .i_delay(delay), .o_rsp(rsp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
  // polls are bounded so a stuck busy flag ends as a mismatch, not a hang
  task automatic wait_ready();
    int k;
    k = 0;
    s = 8'h00;
    while (s[7] !== 1'b1 && k < 200) begin
      rd(ADDR_STATUS, s);
      k++;
    end
    `CHK(s[7], 1'b1)
    repeat (2) @(posedge core_clk);
  endtask
  task automatic run_susp(input logic held, input logic [7:0] c2, input logic iv,
                          input logic exp);
    delay <= 8'h3C;
    wr(ADDR_CTRL0, held ? 8'hE6 : 8'hE2);
    wr(ADDR_BLOCK, 8'h05);
    wr(ADDR_COMMAND, CMD_ERASE);
    @(posedge core_clk);
    access <= '{1'b1, 4'h5};
    @(posedge core_clk);
    access <= '0;
    #1;
    `CHK(blocked, 1'b1)
    `CHK(cpu_hold, held)
    wr(ADDR_CTRL2, c2);
    irq <= iv;
    repeat (10) @(posedge core_clk);
    rd(ADDR_STATUS, s);
    `CHK(s[6], exp)
    if (exp) begin
      `CHK(array_mode, 1'b1)
      wr(ADDR_COMMAND, CMD_PROGRAM);
      #1;
      `CHK(req.start, 1'b1)
      wait_ready();
      rd(ADDR_STATUS, s);
      `CHK(s[6], 1'b1)
      irq <= 1'b0;
      wr(ADDR_CTRL2, 8'h00);
      wr(ADDR_COMMAND, CMD_RESUME);
    end
    irq <= 1'b0;
    wr(ADDR_CTRL2, 8'h00);
    wait_ready();
    rd(ADDR_STATUS, s);
    `CHK(s[6], 1'b0)
    wr(ADDR_STATUS, 8'h00);
  endtask
  task automatic close_out();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(ADDR_STATUS, s);
    `CHK(s & 8'hFB, STATUS_RESET)
    rd(ADDR_CTRL0, s);
    `CHK(s, 8'h00)
    rd(ADDR_COMMAND, s);
    `CHK(s, 8'h00)
    rd(10'h3FF, s);
    `CHK(s, 8'h00)
    wr(ADDR_CTRL0, 8'h62);
    wr(ADDR_COMMAND, CMD_PROGRAM);
    wait_ready();
    rd(ADDR_STATUS, s);
    `CHK(s, 8'h84)
    wr(ADDR_CTRL0, 8'hE2);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_COMMAND, CMD_CLEAR);
      fail   <= ROW_FAIL[i];
      locked <= ROW_LOCK[i];
      wr(ADDR_BLOCK, 8'h01 + 8'(i));
      wr(ADDR_COMMAND, ROW_CMD[i]);
      #1;
      `CHK(req.op, ROW_OP[i])
      wait_ready();
      rd(ADDR_STATUS, s);
      `CHK(s & 8'hF3, 8'h81 | ROW_ERR[i] | (ROW_FAIL[i] ? 8'h02 : 8'h00))
      if (ROW_UPD[i]) `CHK(s[2], ~ROW_LOCK[i])
      wr(ADDR_STATUS, 8'h00);
    end
    fail <= 1'b0;
    wr(ADDR_COMMAND, CMD_CLEAR);
    wr(ADDR_COMMAND, CMD_PROGRAM);
    wait_ready();
    wr(ADDR_STATUS, 8'hFF);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, s);
    `CHK(s, 8'h85)
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, s);
    `CHK(s, 8'h85)
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, s);
    `CHK(s, 8'h84)
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, s);
    `CHK(s, 8'h84)
    wr(ADDR_COMMAND, 8'h09);
    rd(ADDR_STATUS, s);
    `CHK(s & 8'hF3, 8'hB2)
    wr(ADDR_COMMAND, CMD_CLEAR);
    rd(ADDR_STATUS, s);
    `CHK(s & 8'hF3, 8'h80)
    delay <= 8'hC8;
    wr(ADDR_COMMAND, CMD_ERASE);
    wr(ADDR_CTRL0, 8'hF2);
    #1;
    `CHK(req.abort, 1'b1)
    wait_ready();
    rd(ADDR_STATUS, s);
    `CHK(s[0], 1'b1)
    wr(ADDR_STATUS, 8'h00);
    run_susp(1'b0, 8'h03, 1'b0, 1'b1);
    run_susp(1'b0, 8'h05, 1'b1, 1'b1);
    run_susp(1'b0, 8'h06, 1'b1, 1'b0);
    run_susp(1'b1, 8'h03, 1'b0, 1'b0);
    run_susp(1'b1, 8'h07, 1'b1, 1'b1);
    // flash stop: busy while powering down, ready once stopped
    wr(ADDR_CTRL0, 8'hEA);
    rd(ADDR_STATUS, s);
    `CHK(s[7], 1'b0)
    wait_ready();
    rd(ADDR_STATUS, s);
    `CHK(s & 8'hF3, 8'h81)
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL0, 8'h00);
    wait_ready();
    // with rewrite mode off a command must not start anything
    wr(ADDR_COMMAND, CMD_PROGRAM);
    rd(ADDR_STATUS, s);
    `CHK(s & 8'hF3, 8'h80)
    close_out();
  end
endmodule
`default_nettype wire
